// File: core/swb_ctrl.sv
// Control logic of a single-wire bus transceiver
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "swb_defs.svh"

// Operation
// - Enabled path drives transmit level onto bus
// - Receive outputs follow bus, true and inverted
// - Bus level debounced before receive outputs
// - Long transmit/bus mismatch disables bus driver
// - Both high for enable window re-enables
// - Foreign low forces receive until window
// - Each new mismatch restarts compare timer
// - Compare supervision only when override undriven
// - Status pin low enabled, high disabled
// - Driven override pin forces path state
// - Transmit falling edge starts stuck-low timer
// - Stuck low disables transmit unless override driven, receive continues
// - Minimum high pulse resets stuck-low timer
// - Undervoltage never drives a bus low
// - Bus driver released right after reset
// - Compare timeout nominally 52 us
// - Enable window nominally 1.33 ms
// - Stuck-low timeout nominally 6 ms
module swb_ctrl #(
	parameter int unsigned DEB_CYCLES      = `DEB_CYCLES,
	parameter int unsigned BC_CYCLES       = `BC_CYCLES,
	parameter int unsigned ENA_CYCLES      = `ENA_CYCLES,
	parameter int unsigned LOW_CYCLES      = `LOW_CYCLES,
	parameter int unsigned MIN_HIGH_CYCLES = `MIN_HIGH_CYCLES
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             host_tx_in,
	output logic                  host_rx_out,
	output logic                  host_rx_out_inverted,
	input  wire logic             bus_line_in,
	output logic                  bus_line_out,
	output logic                  bus_line_oe_n,
	input  wire logic             tx_path_status_override_in,
	output logic                  tx_path_status_override_out,
	output logic                  tx_path_status_override_oe_n,
	input  wire logic             override_ext_driven,
	input  wire logic             supply_low,
	input  wire swb_pkg::reg_req_s reg_req,
	output swb_pkg::data_t        reg_rdata,
	output logic                  irq
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	localparam longint unsigned CNT_MAX = (64'h1 << `CNT_W) - 64'h1;

	if (DEB_CYCLES < 1 || DEB_CYCLES > CNT_MAX) begin : g_bad_deb
		$error("DEB_CYCLES out of range");
	end
	if (BC_CYCLES < 1 || BC_CYCLES > CNT_MAX) begin : g_bad_bc
		$error("BC_CYCLES out of range");
	end
	if (ENA_CYCLES < 1 || ENA_CYCLES > CNT_MAX) begin : g_bad_ena
		$error("ENA_CYCLES out of range");
	end
	if (LOW_CYCLES < 1 || LOW_CYCLES > CNT_MAX) begin : g_bad_low
		$error("LOW_CYCLES out of range");
	end
	if (MIN_HIGH_CYCLES < 1 || MIN_HIGH_CYCLES > CNT_MAX) begin : g_bad_hi
		$error("MIN_HIGH_CYCLES out of range");
	end

	localparam swb_pkg::cnt_t DEB_LIM = swb_pkg::cnt_t'(DEB_CYCLES);
	localparam swb_pkg::cnt_t BC_LIM  = swb_pkg::cnt_t'(BC_CYCLES);
	localparam swb_pkg::cnt_t ENA_LIM = swb_pkg::cnt_t'(ENA_CYCLES);
	localparam swb_pkg::cnt_t LOW_LIM = swb_pkg::cnt_t'(LOW_CYCLES);
	localparam swb_pkg::cnt_t HI_LIM  = swb_pkg::cnt_t'(MIN_HIGH_CYCLES);
	localparam swb_pkg::cnt_t ONE     = swb_pkg::cnt_t'(1);

	////////////////////////////////////////////////////////////////////////
	// State

	swb_pkg::state_s state_ff;
	swb_pkg::state_s nxt_state;

	logic           ovr_driven;
	logic           path_en;
	logic           mismatch;
	logic           tx_fall;
	swb_pkg::irq_t  irq_event;
	swb_pkg::irq_t  irq_clear;
	swb_pkg::data_t status_word;

	// Path state from override or supervision
	always_comb begin
		ovr_driven = state_ff.ovd_s;
		if (ovr_driven) begin
			path_en = ~state_ff.ovr_s;
		end else begin
			path_en = (state_ff.bc_state == swb_pkg::BC_ARMED) &
			          ~state_ff.low_trip & ~state_ff.inhibit;
		end
		mismatch = state_ff.tx_s ^ state_ff.bus_f;
		tx_fall  = state_ff.tx_prev & ~state_ff.tx_s;
	end

	// Status word as seen by software
	always_comb begin
		status_word                 = '0;
		status_word[`ST_PATH_EN]   = state_ff.path_en_q;
		status_word[`ST_BC_TRIP]   = state_ff.bc_state == swb_pkg::BC_TRIPPED;
		status_word[`ST_LOW_TRIP]  = state_ff.low_trip;
		status_word[`ST_BUS]       = state_ff.bus_f;
		status_word[`ST_TX]        = state_ff.tx_s;
		status_word[`ST_OVR_DRV]   = state_ff.ovd_s;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_state          = state_ff;
		irq_event          = '0;
		irq_clear          = '0;
		nxt_state.released = 1'b1;

		nxt_state.tx_m1  = host_tx_in;
		nxt_state.tx_s   = state_ff.tx_m1;
		nxt_state.bus_m1 = bus_line_in;
		nxt_state.bus_s  = state_ff.bus_m1;
		nxt_state.ovd_m1 = override_ext_driven;
		nxt_state.ovd_s  = state_ff.ovd_m1;
		nxt_state.ovr_m1 = tx_path_status_override_in;
		nxt_state.ovr_s  = state_ff.ovr_m1;
		nxt_state.uv_m1  = supply_low;
		nxt_state.uv_s   = state_ff.uv_m1;
		nxt_state.tx_prev = state_ff.tx_s;

		if (state_ff.bus_s != state_ff.bus_f) begin
			if (state_ff.deb_cnt + ONE >= DEB_LIM) begin
				nxt_state.bus_f   = state_ff.bus_s;
				nxt_state.deb_cnt = '0;
			end else begin
				nxt_state.deb_cnt = state_ff.deb_cnt + ONE;
			end
		end else begin
			nxt_state.deb_cnt = '0;
		end

		nxt_state.rx   = state_ff.bus_f;
		nxt_state.rx_n = ~state_ff.bus_f;

		// Bit-compare supervision
		nxt_state.mis_prev = mismatch & path_en;
		case (state_ff.bc_state)
			swb_pkg::BC_ARMED: begin
				nxt_state.ena_cnt = '0;
				if (!ovr_driven && path_en && mismatch) begin
					if (!state_ff.mis_prev) begin
						nxt_state.bc_cnt = ONE;
					end else begin
						nxt_state.bc_cnt = state_ff.bc_cnt + ONE;
					end
					if (state_ff.bc_cnt >= BC_LIM) begin
						nxt_state.bc_state = swb_pkg::BC_TRIPPED;
						nxt_state.bc_cnt   = '0;
						irq_event[`IRQ_BC_TRIP] = 1'b1;
					end
				end else begin
					nxt_state.bc_cnt = '0;
				end
			end
			swb_pkg::BC_TRIPPED: begin
				nxt_state.bc_cnt = '0;
				if (state_ff.tx_s && state_ff.bus_f) begin
					nxt_state.ena_cnt = state_ff.ena_cnt + ONE;
					if (state_ff.ena_cnt + ONE >= ENA_LIM) begin
						nxt_state.bc_state = swb_pkg::BC_ARMED;
						nxt_state.ena_cnt  = '0;
						irq_event[`IRQ_REENABLE] = 1'b1;
					end
				end else begin
					nxt_state.ena_cnt = '0;
				end
			end
			default: begin
				nxt_state.bc_state = swb_pkg::BC_TRIPPED;
				nxt_state.bc_cnt   = '0;
				nxt_state.ena_cnt  = '0;
			end
		endcase

		if (tx_fall) begin
			nxt_state.low_run = 1'b1;
			nxt_state.low_cnt = ONE;
		end else if (state_ff.low_run && !state_ff.tx_s) begin
			if (state_ff.low_cnt >= LOW_LIM) begin
				if (!state_ff.low_trip) begin
					irq_event[`IRQ_LOW_TRIP] = 1'b1;
				end
				nxt_state.low_trip = 1'b1;
			end else begin
				nxt_state.low_cnt = state_ff.low_cnt + ONE;
			end
		end

		if (state_ff.tx_s) begin
			if (state_ff.hi_cnt + ONE >= HI_LIM) begin
				nxt_state.hi_cnt   = HI_LIM;
				nxt_state.low_run  = 1'b0;
				nxt_state.low_cnt  = '0;
				nxt_state.low_trip = 1'b0;
			end else begin
				nxt_state.hi_cnt = state_ff.hi_cnt + ONE;
			end
		end else begin
			nxt_state.hi_cnt = '0;
		end

		// Registered path state, override pin change event
		nxt_state.path_en_q = path_en;
		nxt_state.ovd_q     = ovr_driven;
		if (ovr_driven != state_ff.ovd_q) begin
			irq_event[`IRQ_OVR_CHG] = 1'b1;
		end

		nxt_state.bus_oe_n = ~(state_ff.released & path_en &
		                       ~state_ff.tx_s & ~state_ff.uv_s);

		nxt_state.ovr_out  = ~path_en;
		nxt_state.ovr_oe_n = ovr_driven;

		// Register writes
		if (reg_req.wr) begin
			case (reg_req.addr)
				`CTRL_OFS: begin
					nxt_state.inhibit = reg_req.wdata[`CTRL_INHIBIT];
				end
				`IRQ_STAT_OFS: begin
					irq_clear = reg_req.wdata[`IRQ_W-1:0];
				end
				`IRQ_MASK_OFS: begin
					nxt_state.irq_mask = reg_req.wdata[`IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Sticky events, set wins over clear
		nxt_state.irq_stat = (state_ff.irq_stat & ~irq_clear) | irq_event;
		nxt_state.irq      = |(nxt_state.irq_stat & nxt_state.irq_mask);

		// Register reads, data valid one cycle later
		nxt_state.rdata = '0;
		if (reg_req.rd) begin
			case (reg_req.addr)
				`CTRL_OFS: begin
					nxt_state.rdata[`CTRL_INHIBIT] = state_ff.inhibit;
				end
				`STATUS_OFS: begin
					nxt_state.rdata = status_word;
				end
				`IRQ_STAT_OFS: begin
					nxt_state.rdata[`IRQ_W-1:0] = state_ff.irq_stat;
				end
				`IRQ_MASK_OFS: begin
					nxt_state.rdata[`IRQ_W-1:0] = state_ff.irq_mask;
				end
				default: begin
					nxt_state.rdata = '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff          <= '0;
			state_ff.tx_m1    <= 1'b1;
			state_ff.tx_s     <= 1'b1;
			state_ff.tx_prev  <= 1'b1;
			state_ff.bus_m1   <= 1'b1;
			state_ff.bus_s    <= 1'b1;
			state_ff.bus_f    <= 1'b1;
			state_ff.rx       <= 1'b1;
			state_ff.rx_n     <= 1'b0;
			state_ff.bc_state <= swb_pkg::BC_ARMED;
			state_ff.bus_oe_n <= 1'b1;
			state_ff.ovr_out  <= 1'b0;
			state_ff.ovr_oe_n <= 1'b1;
			state_ff.inhibit  <= `CTRL_RST;
			state_ff.irq_mask <= `IRQ_MASK_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Open-drain bus: data is always low, enable carries the bit
	assign bus_line_out                 = 1'b0;
	assign bus_line_oe_n                = state_ff.bus_oe_n;
	assign host_rx_out                  = state_ff.rx;
	assign host_rx_out_inverted         = state_ff.rx_n;
	assign tx_path_status_override_out  = state_ff.ovr_out;
	assign tx_path_status_override_oe_n = state_ff.ovr_oe_n;
	assign reg_rdata                    = state_ff.rdata;
	assign irq                          = state_ff.irq;

endmodule

// File: core/swb_defs.svh
// Timing counts, register offsets, field positions and reset values
`ifndef SWB_DEFS_SVH
`define SWB_DEFS_SVH

// Clock period in ns
`define CLK_PERIOD_NS   100

// Documented times in ns
`define DEB_TIME_NS     2800
`define BC_TIME_NS      52000
`define ENA_TIME_NS     1330000
`define LOW_TIME_NS     6000000
`define MIN_HIGH_NS     1000

// Cycle counts, rounded up to whole cycles
`define DEB_CYCLES      ((`DEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BC_CYCLES       ((`BC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENA_CYCLES      ((`ENA_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_CYCLES      ((`LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_HIGH_CYCLES ((`MIN_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Widths
`define CNT_W           20
`define ADDR_W          4
`define DATA_W          32
`define IRQ_W           4

// Register offsets
`define CTRL_OFS        4'h0
`define STATUS_OFS      4'h4
`define IRQ_STAT_OFS    4'h8
`define IRQ_MASK_OFS    4'hC

// Control fields
`define CTRL_INHIBIT    0

// Status fields
`define ST_PATH_EN      0
`define ST_BC_TRIP      1
`define ST_LOW_TRIP     2
`define ST_BUS          3
`define ST_TX           4
`define ST_OVR_DRV      5

// Interrupt fields
`define IRQ_BC_TRIP     0
`define IRQ_LOW_TRIP    1
`define IRQ_REENABLE    2
`define IRQ_OVR_CHG     3

// Reset values
`define CTRL_RST        1'h0
`define IRQ_MASK_RST    4'h0

`endif

// File: core/swb_pkg.sv
// Types of the single-wire bus transceiver control
`include "swb_defs.svh"

package swb_pkg;

	typedef logic [`CNT_W-1:0]  cnt_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`DATA_W-1:0] data_t;
	typedef logic [`IRQ_W-1:0]  irq_t;

	// Bit-compare supervision states
	typedef enum logic [1:0] {
		BC_ARMED   = 2'b00,
		BC_TRIPPED = 2'b01
	} bc_state_e;

	// Register port request
	typedef struct packed {
		addr_t addr;
		data_t wdata;
		logic  wr;
		logic  rd;
	} reg_req_s;

	// Whole state of the control block
	typedef struct packed {
		logic      released;
		logic      tx_m1;
		logic      tx_s;
		logic      bus_m1;
		logic      bus_s;
		logic      ovd_m1;
		logic      ovd_s;
		logic      ovr_m1;
		logic      ovr_s;
		logic      uv_m1;
		logic      uv_s;
		logic      bus_f;
		cnt_t      deb_cnt;
		logic      rx;
		logic      rx_n;
		logic      tx_prev;
		logic      mis_prev;
		bc_state_e bc_state;
		cnt_t      bc_cnt;
		cnt_t      ena_cnt;
		logic      low_run;
		logic      low_trip;
		cnt_t      low_cnt;
		cnt_t      hi_cnt;
		logic      path_en_q;
		logic      ovd_q;
		logic      bus_oe_n;
		logic      ovr_out;
		logic      ovr_oe_n;
		logic      inhibit;
		irq_t      irq_stat;
		irq_t      irq_mask;
		data_t     rdata;
		logic      irq;
	} state_s;

endpackage

// File: tb/swb_ctrl_assertions.sv
// Port checks of the transceiver control
`timescale 1ns/100ps
module swb_ctrl_assertions #(
	parameter int unsigned DEB_CYCLES = 28
) (
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              host_rx_out,
	input wire logic              host_rx_out_inverted,
	input wire logic              bus_line_in,
	input wire logic              bus_line_out,
	input wire logic              bus_line_oe_n,
	input wire logic              tx_path_status_override_out,
	input wire logic              tx_path_status_override_oe_n,
	input wire logic              override_ext_driven,
	input wire logic              supply_low,
	input wire swb_pkg::reg_req_s reg_req,
	input wire swb_pkg::data_t    reg_rdata
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	logic [7:0] run_ff;
	logic       bus_q_ff;
	////////////////////////////////////////////////////////////////////
	// Length of the current steady run on the bus input
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_ff <= 8'h00;
			bus_q_ff <= 1'b1;
		end else begin
			bus_q_ff <= bus_line_in;
			if (bus_line_in != bus_q_ff) begin
				run_ff <= 8'h00;
			end else if (run_ff != 8'hFF) begin
				run_ff <= run_ff + 8'h01;
			end
		end
	end
	// Steps of the supply and pin ownership behaviour
	sequence s_uv_held;
		supply_low[*3];
	endsequence
	sequence s_pin_free;
		override_ext_driven[*4];
	endsequence
	sequence s_pin_owned;
		!override_ext_driven[*4];
	endsequence
	////////////////////////////////////////////////////////////////////
	a_rx_complement: assert property (
		host_rx_out_inverted == !host_rx_out)
		else $error("receive outputs not complementary");
	a_rx_debounce: assert property (
		$changed(host_rx_out) |-> $past(bus_line_in, 4) == host_rx_out
		&& $past(run_ff, 4) >= DEB_CYCLES - 4)
		else $error("receive output moved without a steady bus");
	a_reset_bus_hiz: assert property (
		disable iff (1'b0) !reset_n |=> bus_line_oe_n)
		else $error("bus driven right after reset");
	a_uv_no_drive: assert property (s_uv_held |=> bus_line_oe_n)
		else $error("bus driven in undervoltage");
	a_bus_data_low: assert property (bus_line_out == 1'b0)
		else $error("bus data not low");
	a_pin_released: assert property (
		s_pin_free |=> tx_path_status_override_oe_n)
		else $error("status pin driven against outside party");
	a_pin_driven: assert property (
		s_pin_owned |=> !tx_path_status_override_oe_n)
		else $error("status pin not driven while free");
	a_status_enabled: assert property (
		!bus_line_oe_n |-> ##[0:2] !tx_path_status_override_out)
		else $error("status pin not low while transmitting");
	a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 32'h0)
		else $error("read data outside read answer");
	a_unmapped_zero: assert property (
		reg_req.rd && reg_req.addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

// File: tb/swb_bus_node.sv
// Other bus node with pull-up and the outside status pin party
`timescale 1ns/100ps
module swb_bus_node (
	input wire logic dev_oe_n,
	input wire logic pull_low,
	input wire logic pin_oe_n,
	input wire logic pin_out,
	input wire logic ext_drive,
	input wire logic ext_level,
	output logic     bus_level,
	output logic     pin_level
);
	// foreign low wins
	// Wired-AND bus, released wire returns to the pull-up level
	assign bus_level = !(dev_oe_n === 1'b0 || pull_low);
	// outside party overrides
	// Free pin sits at its pull-down level
	assign pin_level = ext_drive ? ext_level
		: (pin_oe_n === 1'b0 ? pin_out : 1'b0);
endmodule

// File: tb/testbench.sv
// Self-checking bench of the transceiver control
`timescale 1ns/100ps
module testbench;
	localparam int unsigned ENA = 50;
	localparam int unsigned LOW = 200;
	logic              clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              tx = 1'b1;
	logic              pull = 1'b0;
	logic              ext = 1'b0;
	logic              ext_lvl = 1'b0;
	logic              uv = 1'b0;
	swb_pkg::reg_req_s req = '0;
	logic              rx, rx_n, bus, oe_n, pin, pin_out, pin_oe_n, irq;
	swb_pkg::data_t    rdata;
	int                num_errors = 0;
	int                checks = 0;
	always #50 clk = ~clk;
	swb_ctrl #(.ENA_CYCLES(ENA), .LOW_CYCLES(LOW)) u_dut (
		.clk(clk), .reset_n(reset_n), .host_tx_in(tx),
		.host_rx_out(rx), .host_rx_out_inverted(rx_n),
		.bus_line_in(bus), .bus_line_out(), .bus_line_oe_n(oe_n),
		.tx_path_status_override_in(pin),
		.tx_path_status_override_out(pin_out),
		.tx_path_status_override_oe_n(pin_oe_n),
		.override_ext_driven(ext), .supply_low(uv),
		.reg_req(req), .reg_rdata(rdata), .irq(irq));
	swb_bus_node u_node (.dev_oe_n(oe_n), .pull_low(pull),
		.pin_oe_n(pin_oe_n), .pin_out(pin_out), .ext_drive(ext),
		.ext_level(ext_lvl), .bus_level(bus), .pin_level(pin));
	////////////////////////////////////////////////////////////////////
	// Compare, count and report
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Register port cycles
	task automatic wr(swb_pkg::addr_t a, swb_pkg::data_t d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(string name, swb_pkg::addr_t a, swb_pkg::data_t e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(name, rdata, e);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		cyc(4);
		chk("oe_n", oe_n, 1);
		chk("rx_n", rx_n, 0);
		@(posedge clk) reset_n <= 1'b1;
		cyc(5);
		rd("ctrl", 4'h0, 32'h0);
		rd("unmapped", 4'h2, 32'h0);
		rd("status", 4'h4, 32'h19);
		wr(4'hC, 32'hF);
		rd("mask", 4'hC, 32'hF);
		$display("test reset done");
		@(posedge clk) tx <= 1'b0;
		cyc(4);
		chk("bus", bus, 0);
		chk("pin", pin, 0);
		cyc(35);
		chk("rx", rx, 0);
		@(posedge clk) tx <= 1'b1;
		cyc(40);
		@(posedge clk) pull <= 1'b1;
		cyc(10);
		@(posedge clk) pull <= 1'b0;
		cyc(40);
		chk("spike rx", rx, 1);
		repeat (2) begin
			@(posedge clk) pull <= 1'b1;
			cyc(400);
			@(posedge clk) pull <= 1'b0;
			cyc(40);
		end
		rd("status", 4'h4, 32'h19);
		$display("test transmit done");
		@(posedge clk) pull <= 1'b1;
		cyc(600);
		chk("pin", pin, 1);
		rd("status", 4'h4, 32'h12);
		chk("irq", irq, 1);
		wr(4'hC, 32'h0);
		cyc(2);
		chk("masked irq", irq, 0);
		wr(4'hC, 32'hF);
		wr(4'h8, 32'hF);
		cyc(2);
		chk("cleared irq", irq, 0);
		@(posedge clk) tx <= 1'b0;
		cyc(5);
		chk("oe_n", oe_n, 1);
		@(posedge clk) tx <= 1'b1;
		@(posedge clk) pull <= 1'b0;
		cyc(20);
		rd("status", 4'h4, 32'h12);
		cyc(ENA + 40);
		rd("status", 4'h4, 32'h19);
		wr(4'h8, 32'hF);
		$display("test compare done");
		@(posedge clk) tx <= 1'b0;
		cyc(150);
		@(posedge clk) tx <= 1'b1;
		cyc(15);
		@(posedge clk) tx <= 1'b0;
		cyc(150);
		chk("oe_n", oe_n, 0);
		cyc(80);
		chk("oe_n", oe_n, 1);
		cyc(40);
		chk("rx", rx, 1);
		rd("status", 4'h4, 32'h0C);
		@(posedge clk) tx <= 1'b1;
		cyc(40);
		rd("status", 4'h4, 32'h19);
		wr(4'h8, 32'hF);
		$display("test stuck low done");
		@(posedge clk) ext <= 1'b1;
		ext_lvl <= 1'b1;
		cyc(5);
		@(posedge clk) tx <= 1'b0;
		cyc(5);
		chk("oe_n", oe_n, 1);
		chk("pin_oe_n", pin_oe_n, 1);
		@(posedge clk) ext_lvl <= 1'b0;
		cyc(LOW + 50);
		chk("oe_n", oe_n, 0);
		@(posedge clk) tx <= 1'b1;
		cyc(40);
		@(posedge clk) ext <= 1'b0;
		cyc(40);
		// Stuck-low trip still flagged under override, plus pin changes
		rd("irq stat", 4'h8, 32'hA);
		wr(4'h8, 32'hF);
		$display("test override done");
		wr(4'h0, 32'h1);
		rd("ctrl", 4'h0, 32'h1);
		@(posedge clk) uv <= 1'b1;
		tx <= 1'b0;
		cyc(5);
		chk("oe_n", oe_n, 1);
		wr(4'h0, 32'h0);
		cyc(5);
		chk("uv oe_n", oe_n, 1);
		@(posedge clk) tx <= 1'b1;
		uv <= 1'b0;
		cyc(10);
		$display("test inhibit done");
		give_verdict();
	end
	// Cut a hang short
	initial begin
		#2000000;
		num_errors++;
		give_verdict();
	end
endmodule
bind swb_ctrl swb_ctrl_assertions #(.DEB_CYCLES(DEB_CYCLES)) u_chk (
	.clk(clk), .reset_n(reset_n), .host_rx_out(host_rx_out),
	.host_rx_out_inverted(host_rx_out_inverted), .bus_line_in(bus_line_in),
	.bus_line_out(bus_line_out), .bus_line_oe_n(bus_line_oe_n),
	.tx_path_status_override_out(tx_path_status_override_out),
	.tx_path_status_override_oe_n(tx_path_status_override_oe_n),
	.override_ext_driven(override_ext_driven), .supply_low(supply_low),
	.reg_req(reg_req), .reg_rdata(reg_rdata));
